// *** hdl/oa_cfg.svh ***
// operand a block constants: offsets, fields, reset values
`ifndef OA_CFG_SVH
`define OA_CFG_SVH
`define OA_WORD_W      16
`define OA_BYTE_W      8
`define OA_OFF_CTRL    8'h00
`define OA_OFF_ROT     8'h04
`define OA_OFF_OPND    8'h08
`define OA_OFF_ACC1    8'h0C
`define OA_OFF_ACC2    8'h10
`define OA_OFF_ACC3    8'h14
`define OA_OFF_XOUT    8'h18
`define OA_OFF_STAT    8'h1C
`define OA_CTRL_CODE_LSB 0
`define OA_CTRL_LOAD_LSB 3
`define OA_CTRL_OVR_BIT  8
`define OA_CTRL_RST    32'h0000_0000
`define OA_ACC_RST     16'h0000
`endif

// *** hdl/oa_operand_a.sv ***
// operand a registers, x selector and ahb-lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "oa_cfg.svh"
module oa_operand_a
	import oa_pkg::*;
#(
	parameter int unsigned WIDTH  = `OA_WORD_W,
	parameter int unsigned BYTE_W = `OA_BYTE_W
) (
	// system
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// ahb-lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	// controls from the microcode control register
	input  wire logic              phase_three_clock,
	input  wire logic              load_bit_one,
	input  wire logic              load_bit_two,
	input  wire logic              load_bit_three,
	input  wire logic              xsel_code_bit_hi,
	input  wire logic              xsel_code_bit_mid,
	input  wire logic              xsel_code_bit_lo,
	// operand sources
	input  wire logic [WIDTH-1:0]  rotator_output,
	input  wire logic [BYTE_W-1:0] immediate_value_reg,
	input  wire logic [BYTE_W-1:0] loop_count_reg,
	// adder x operand and decoded controls
	output logic [WIDTH-1:0]       x_operand,
	output var oa_xctl_s           x_ctl
);

	// bus state
	logic              wr_pend_reg;
	logic [7:0]        addr_reg;
	logic [31:0]       ctrl_reg;
	logic [WIDTH-1:0]  rot_reg;
	logic [31:0]       opnd_reg;
	logic              sw_step_reg;
	// datapath state
	logic [WIDTH-1:0]  acc_reg_one;
	logic [WIDTH-1:0]  acc_reg_two;
	logic [WIDTH-1:0]  acc_reg_three;
	logic [WIDTH-1:0]  x_operand_reg;
	oa_xctl_s          x_ctl_reg;
	// combinational
	logic              addr_phase;
	logic              sw_mode;
	oa_xcode_e         xcode;
	oa_load_s          strobe;
	oa_xctl_s          ctl_next;
	logic [WIDTH-1:0]  rot_word;
	logic [BYTE_W-1:0] imm_byte;
	logic [BYTE_W-1:0] cnt_byte;
	logic [WIDTH-1:0]  x_next;
	logic [31:0]       rdata_next;
	logic              wr_ctrl;
	logic              wr_rot;
	logic              wr_opnd;
	logic [WIDTH-1:0]  z_word;

	// one register stage covers every access, so no wait state is ever needed
	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;
	assign addr_phase = hsel && hready && htrans[1];
	assign sw_mode    = ctrl_reg[`OA_CTRL_OVR_BIT];

	// address phase capture; every transfer is zero wait
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
		end else begin
			wr_pend_reg <= addr_phase && hwrite;
		end
	end

	// reads need no pending flag: their data is loaded in the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_reg <= 8'h00;
		end else begin
			addr_reg <= haddr[7:0];
		end
	end

	// write decode, one strobe per writable register
	assign wr_ctrl = wr_pend_reg && (addr_reg == `OA_OFF_CTRL);
	assign wr_rot  = wr_pend_reg && (addr_reg == `OA_OFF_ROT);
	assign wr_opnd = wr_pend_reg && (addr_reg == `OA_OFF_OPND);

	// software writes; only whole words are meaningful, hsize is not checked
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= `OA_CTRL_RST;
		end else if (wr_ctrl) begin
			// unused bits are dropped here so they always read back as zero
			ctrl_reg <= hwdata & 32'h0000_013F;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rot_reg <= `OA_ACC_RST;
		end else if (wr_rot) begin
			rot_reg <= hwdata[WIDTH-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			opnd_reg <= 32'h0000_0000;
		end else if (wr_opnd) begin
			opnd_reg <= {16'h0000, hwdata[15:0]};
		end
	end

	// a control write in software mode issues one load step
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sw_step_reg <= 1'b0;
		end else begin
			// the step lands with the new control word, so it uses the new load bits
			sw_step_reg <= wr_ctrl && hwdata[`OA_CTRL_OVR_BIT];
		end
	end

	// source select: pins normally, registers under software override
	always_comb begin
		rot_word = rotator_output;
		imm_byte = immediate_value_reg;
		cnt_byte = loop_count_reg;
		xcode    = oa_xcode_e'({xsel_code_bit_hi, xsel_code_bit_mid, xsel_code_bit_lo});
		strobe   = '{load_strobe_three: load_bit_three && phase_three_clock,
			load_strobe_two: load_bit_two && phase_three_clock,
			load_strobe_one: load_bit_one && phase_three_clock};
		if (sw_mode) begin
			rot_word = rot_reg;
			imm_byte = opnd_reg[BYTE_W-1:0];
			cnt_byte = opnd_reg[2*BYTE_W-1:BYTE_W];
			xcode    = oa_xcode_e'(ctrl_reg[`OA_CTRL_CODE_LSB +: 3]);
			strobe   = oa_load_s'(ctrl_reg[`OA_CTRL_LOAD_LSB +: 3] & {3{sw_step_reg}});
		end
	end

	// nanoword code to enables and selects
	always_comb begin
		ctl_next = '{1'b0, 1'b0, 1'b0, OA_SEL_CONCAT};
		unique case (xcode)
			OA_X_ZERO: begin
				ctl_next = '{1'b0, 1'b0, 1'b0, OA_SEL_CONCAT};
			end
			OA_X_IMM: begin
				ctl_next = '{1'b0, 1'b0, 1'b1, OA_SEL_CONCAT};
			end
			OA_X_RSVD: begin
				ctl_next = '{1'b0, 1'b0, 1'b0, OA_SEL_CONCAT};
			end
			OA_X_COUNT: begin
				ctl_next = '{1'b1, 1'b0, 1'b0, OA_SEL_CONCAT};
			end
			OA_X_CONCAT: begin
				ctl_next = '{1'b1, 1'b0, 1'b1, OA_SEL_CONCAT};
			end
			OA_X_ONE: begin
				ctl_next = '{1'b1, 1'b1, 1'b1, OA_SEL_ONE};
			end
			OA_X_TWO: begin
				ctl_next = '{1'b1, 1'b1, 1'b1, OA_SEL_TWO};
			end
			OA_X_THREE: begin
				ctl_next = '{1'b1, 1'b1, 1'b1, OA_SEL_THREE};
			end
		endcase
	end

	// a registers: each strobe alone decides, so any mix loads one word
	// they have no reset of their own; zero keeps them free of unknowns
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_reg_one <= `OA_ACC_RST;
		end else if (strobe.load_strobe_one) begin
			acc_reg_one <= rot_word;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_reg_two <= `OA_ACC_RST;
		end else if (strobe.load_strobe_two) begin
			acc_reg_two <= rot_word;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_reg_three <= `OA_ACC_RST;
		end else if (strobe.load_strobe_three) begin
			acc_reg_three <= rot_word;
		end
	end

	// counter and immediate bytes, each gated by its own enable
	always_comb begin
		z_word = '0;
		if (ctl_next.x_high_byte_enable) begin
			z_word[WIDTH-1 -: BYTE_W] = cnt_byte;
		end
		if (ctl_next.x_low_byte_enable) begin
			z_word[BYTE_W-1:0] = imm_byte;
		end
	end

	// x selector; middle enable only qualifies register transfers
	always_comb begin
		x_next = '0;
		if (ctl_next.x_high_byte_enable || ctl_next.x_mid_enable
			|| ctl_next.x_low_byte_enable) begin
			unique case (ctl_next.x_reg_select)
				OA_SEL_THREE: begin
					x_next = acc_reg_three;
				end
				OA_SEL_TWO: begin
					x_next = acc_reg_two;
				end
				OA_SEL_ONE: begin
					x_next = acc_reg_one;
				end
				OA_SEL_CONCAT: begin
					x_next = z_word;
				end
			endcase
		end
	end // all enables false leaves zero

	// registered x operand toward the adder, in the same cycle as its registered controls
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			x_operand_reg <= '0;
		end else begin
			x_operand_reg <= x_next;
		end
	end

	// controls are registered too, so they line up with the operand they made
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			x_ctl_reg <= '{1'b0, 1'b0, 1'b0, OA_SEL_CONCAT};
		end else begin
			x_ctl_reg <= ctl_next;
		end
	end

	assign x_operand = x_operand_reg;
	assign x_ctl     = x_ctl_reg;

	// read data is prepared in the address phase so it stands in the data phase
	always_comb begin
		rdata_next = 32'h0000_0000;
		unique case (haddr[7:0])
			`OA_OFF_CTRL: begin
				rdata_next = ctrl_reg;
			end
			`OA_OFF_ROT: begin
				rdata_next = {16'h0000, rot_reg};
			end
			`OA_OFF_OPND: begin
				rdata_next = opnd_reg;
			end
			`OA_OFF_ACC1: begin
				rdata_next = {16'h0000, acc_reg_one};
			end
			`OA_OFF_ACC2: begin
				rdata_next = {16'h0000, acc_reg_two};
			end
			`OA_OFF_ACC3: begin
				rdata_next = {16'h0000, acc_reg_three};
			end
			`OA_OFF_XOUT: begin
				rdata_next = {16'h0000, x_operand_reg};
			end
			`OA_OFF_STAT: begin
				rdata_next = {27'h0000000, x_ctl_reg};
			end
			default: begin
				rdata_next = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_phase && !hwrite) begin
			hrdata <= rdata_next;
		end
	end

endmodule
`default_nettype wire

// *** hdl/oa_pkg.sv ***
// operand a block types
`default_nettype none
package oa_pkg;
	typedef enum logic [2:0] {
		OA_X_ZERO   = 3'b000,
		OA_X_IMM    = 3'b001,
		OA_X_RSVD   = 3'b010,
		OA_X_COUNT  = 3'b011,
		OA_X_CONCAT = 3'b100,
		OA_X_ONE    = 3'b101,
		OA_X_TWO    = 3'b110,
		OA_X_THREE  = 3'b111
	} oa_xcode_e;
	typedef enum logic [1:0] {
		OA_SEL_THREE  = 2'b00,
		OA_SEL_TWO    = 2'b01,
		OA_SEL_ONE    = 2'b10,
		OA_SEL_CONCAT = 2'b11
	} oa_sel_e;
	typedef struct packed {
		logic    x_high_byte_enable;
		logic    x_mid_enable;
		logic    x_low_byte_enable;
		oa_sel_e x_reg_select;
	} oa_xctl_s;
	typedef struct packed {
		logic load_strobe_three;
		logic load_strobe_two;
		logic load_strobe_one;
	} oa_load_s;
endpackage
`default_nettype wire

// *** test/oa_ctl_model.sv ***
// control register and nanoword decode model
`timescale 1ns/10ps
`default_nettype none
module oa_ctl_model (
	// clock
	input  wire logic  hclk,
	// nanoword controls
	output logic       phase_three_clock,
	output logic       load_bit_one,
	output logic       load_bit_two,
	output logic       load_bit_three,
	output logic       xsel_code_bit_hi,
	output logic       xsel_code_bit_mid,
	output logic       xsel_code_bit_lo,
	// operand sources
	output logic [15:0] rotator_output,
	output logic [7:0]  immediate_value_reg,
	output logic [7:0]  loop_count_reg
);
	initial begin
		{phase_three_clock, load_bit_three, load_bit_two, load_bit_one} = 4'h0;
		{xsel_code_bit_hi, xsel_code_bit_mid, xsel_code_bit_lo} = 3'b000;
		{rotator_output, immediate_value_reg, loop_count_reg} = 32'h0;
	end
	// one microinstruction; values then stand until the next step
	task automatic step(input logic [2:0] code, input logic [2:0] ld, input logic ph,
		input logic [15:0] rot, input logic [7:0] imm, input logic [7:0] cnt);
		@(posedge hclk);
		{xsel_code_bit_hi, xsel_code_bit_mid, xsel_code_bit_lo} <= code;
		{load_bit_three, load_bit_two, load_bit_one} <= ld;
		phase_three_clock <= ph;
		rotator_output <= rot;
		immediate_value_reg <= imm;
		loop_count_reg <= cnt;
	endtask
endmodule
`default_nettype wire

// *** test/oa_operand_a_asserts.sv ***
// port assertions for the operand a block
`timescale 1ns/10ps
`default_nettype none
module oa_chk
	import oa_pkg::*;
#(
	parameter int unsigned WIDTH  = 16,
	parameter int unsigned BYTE_W = 8
) (
	// system
	input wire logic              hclk,
	input wire logic              hresetn,
	// controls
	input wire logic              phase_three_clock,
	input wire logic              load_bit_one,
	input wire logic              load_bit_two,
	input wire logic              xsel_code_bit_hi,
	input wire logic              xsel_code_bit_mid,
	input wire logic              xsel_code_bit_lo,
	// sources and result
	input wire logic [WIDTH-1:0]  rotator_output,
	input wire logic [BYTE_W-1:0] immediate_value_reg,
	input wire logic [BYTE_W-1:0] loop_count_reg,
	input wire logic [WIDTH-1:0]  x_operand,
	input wire oa_xctl_s          x_ctl
);
	// pin values; under override the bench keeps the code and byte pins equal to the registers
	wire logic [2:0] code = {xsel_code_bit_hi, xsel_code_bit_mid, xsel_code_bit_lo};
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	zero_out_a: assert property (code == 3'b000 |=> x_operand == '0)
		else $error("zero code gave nonzero x");
	rsvd_zero_a: assert property (code == 3'b010 |=> x_operand == '0)
		else $error("reserved code gave nonzero x");
	imm_low_a: assert property (code == 3'b001
		|=> x_operand == {8'h00, $past(immediate_value_reg)})
		else $error("immediate path wrong");
	cnt_high_a: assert property (code == 3'b011
		|=> x_operand == {$past(loop_count_reg), 8'h00})
		else $error("counter path wrong");
	concat_order_a: assert property (code == 3'b100
		|=> x_operand == {$past(loop_count_reg), $past(immediate_value_reg)})
		else $error("concat order wrong");
	ctl_idle_a: assert property (code == 3'b000 |=> x_ctl == 5'b00011)
		else $error("idle controls wrong");
	mid_unused_a: assert property (code inside {3'b001, 3'b011, 3'b100}
		|=> !x_ctl.x_mid_enable)
		else $error("mid enable used");
	sel_one_a: assert property (code == 3'b101 |=> x_ctl.x_reg_select == OA_SEL_ONE)
		else $error("register one select wrong");
	load_one_a: assert property ((code == 3'b101 && load_bit_one && phase_three_clock)
		##1 code == 3'b101 |=> x_operand == $past(rotator_output, 2))
		else $error("register one not loaded");
	hold_two_a: assert property ((code == 3'b110
		&& !(load_bit_two && phase_three_clock)) ##1 code == 3'b110
		|=> $stable(x_operand))
		else $error("register two changed without load");
endmodule
bind oa_operand_a oa_chk #(.WIDTH(WIDTH), .BYTE_W(BYTE_W)) u_chk (.hclk, .hresetn,
	.phase_three_clock, .load_bit_one, .load_bit_two, .xsel_code_bit_hi, .xsel_code_bit_mid,
	.xsel_code_bit_lo, .rotator_output, .immediate_value_reg, .loop_count_reg, .x_operand, .x_ctl);
`default_nettype wire

// *** test/tb_oa_operand_a.sv ***
// self-checking bench for the operand a block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
	$display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tb_oa_operand_a
	import oa_pkg::*;
;
	logic             hclk = 1'b0;
	logic             hresetn = 1'b0;
	logic             hsel = 1'b1;
	logic             hwrite = 1'b0;
	logic [1:0]       htrans = 2'b00;
	logic [2:0]       hsize = 3'b010;
	logic [31:0]      haddr = 32'h0;
	logic [31:0]      hwdata = 32'h0;
	logic [31:0]      rd;
	logic [15:0]      exp_x;
	wire logic        hreadyout, hresp, phase_three_clock, load_bit_one, load_bit_two;
	wire logic        load_bit_three, xsel_code_bit_hi, xsel_code_bit_mid, xsel_code_bit_lo;
	wire logic [31:0] hrdata;
	wire logic [15:0] rotator_output, x_operand;
	wire logic [7:0]  immediate_value_reg, loop_count_reg;
	wire oa_xctl_s    x_ctl;
	int               fails = 0;
	int               num_checks = 0;
	int               cyc = 0;
	localparam logic [4:0] CTL_TAB [8] = '{5'h03, 5'h07, 5'h03, 5'h13, 5'h17, 5'h1E, 5'h1D, 5'h1C};
	always #5 hclk = ~hclk;
	oa_operand_a u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .phase_three_clock, .load_bit_one,
		.load_bit_two, .load_bit_three, .xsel_code_bit_hi, .xsel_code_bit_mid, .xsel_code_bit_lo,
		.rotator_output, .immediate_value_reg, .loop_count_reg, .x_operand, .x_ctl);
	oa_ctl_model u_ctl (.hclk, .phase_three_clock, .load_bit_one, .load_bit_two, .load_bit_three,
		.xsel_code_bit_hi, .xsel_code_bit_mid, .xsel_code_bit_lo, .rotator_output,
		.immediate_value_reg, .loop_count_reg);
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// single word transfer; waits on hready, never on a fixed count
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'b10;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			close_out();
		end
	end
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			bus(1'b0, 32'h0C + 4 * k, 32'h0);
			`CHK(rd, 32'h0)
		end
		bus(1'b1, 32'h20, 32'hFFFF_FFFF);
		bus(1'b0, 32'h20, 32'h0);
		`CHK(rd, 32'h0)
		bus(1'b1, 32'h00, 32'hFFFF_FEFF);
		bus(1'b0, 32'h00, 32'h0);
		`CHK(rd, 32'h3F)
		bus(1'b1, 32'h00, 32'h0);
		// back-to-back loads, one with the phase off
		u_ctl.step(3'b101, 3'b111, 1'b1, 16'hA5C3, 8'h00, 8'h00);
		u_ctl.step(3'b101, 3'b010, 1'b0, 16'h1234, 8'h00, 8'h00);
		u_ctl.step(3'b110, 3'b010, 1'b1, 16'h5A0F, 8'h00, 8'h00);
		u_ctl.step(3'b101, 3'b001, 1'b1, 16'h0F0F, 8'h00, 8'h00);
		u_ctl.step(3'b101, 3'b000, 1'b1, 16'hFFFF, 8'h00, 8'h00);
		bus(1'b0, 32'h0C, 32'h0);
		`CHK(rd, 32'h0F0F)
		bus(1'b0, 32'h10, 32'h0);
		`CHK(rd, 32'h5A0F)
		bus(1'b0, 32'h14, 32'h0);
		`CHK(rd, 32'hA5C3)
		for (int k = 0; k < 8; k++) begin
			u_ctl.step(k[2:0], 3'b000, 1'b1, 16'hFFFF, 8'h3C, 8'hE1);
			repeat (2) @(posedge hclk);
			#1;
			case (k)
				1: exp_x = 16'h003C;
				3: exp_x = 16'hE100;
				4: exp_x = 16'hE13C;
				5: exp_x = 16'h0F0F;
				6: exp_x = 16'h5A0F;
				7: exp_x = 16'hA5C3;
				default: exp_x = 16'h0000;
			endcase
			`CHK(x_operand, exp_x)
			`CHK(x_ctl, CTL_TAB[k])
		end
		bus(1'b0, 32'h18, 32'h0);
		`CHK(rd, 32'hA5C3)
		// override: code and byte pins mirror the registers; the rotator word and the load step differ
		u_ctl.step(3'b100, 3'b000, 1'b1, 16'hFFFF, 8'hC3, 8'h5A);
		bus(1'b1, 32'h08, 32'h0000_5AC3);
		bus(1'b1, 32'h04, 32'h0000_9999);
		bus(1'b0, 32'h08, 32'h0);
		`CHK(rd, 32'h5AC3)
		bus(1'b0, 32'h04, 32'h0);
		`CHK(rd, 32'h9999)
		bus(1'b1, 32'h00, 32'h0000_010C);
		bus(1'b0, 32'h0C, 32'h0);
		`CHK(rd, 32'h9999)
		bus(1'b0, 32'h1C, 32'h0);
		`CHK(rd, 32'h17)
		bus(1'b0, 32'h18, 32'h0);
		`CHK(rd, 32'h5AC3)
		`CHK(hresp, 1'b0)
		bus(1'b1, 32'h00, 32'h0);
		close_out();
	end
endmodule
`default_nettype wire
